// *** pkg/sab_map.vh ***
// Constants for the serial EEPROM auto-boot loader.
`ifndef SAB_MAP_VH
`define SAB_MAP_VH

`define SAB_CLK_PERIOD_NS 10
`define SAB_SCLK_HALF_NS 500
`define SAB_SCLK_HALF_CYC 8'h32
`define SAB_STRAP_SETTLE 3'h6

`define SAB_READ_OPCODE 8'h03
`define SAB_START_ADDR 8'h00
`define SAB_TX_BITS 4'hF
`define SAB_RX_BITS 3'h7

`define SAB_WR_CLASS 2'h1
`define SAB_CMD_PAGE 8'h7E
`define SAB_CMD_OPMODE 8'h60
`define SAB_CMD_IGAIN 8'h42
`define SAB_CMD_MASK 8'h74
`define SAB_CMD_CTRL 8'h78
`define SAB_PAGE0 5'h00
`define SAB_PAGE1 5'h01
`define SAB_STOP_POS 8

`define SAB_PAGE_RST 5'h00
`define SAB_OPMODE_RST 24'h000000
`define SAB_IGAIN_RST 24'h000000
`define SAB_MASK_RST 24'h000000
`define SAB_CTRL_RST 24'h000000

`endif

// *** rtl/sab_sync.v ***
// Three-stage synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
module sab_sync (
	input wire clk_sys, // System clock.
	input wire nrst, // Asynchronous reset, active low.
	input wire din, // Asynchronous input.
	output reg dout // Filtered, synchronised level.
);
	reg s1;
	reg s2;
	reg s3;

	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
			dout <= 1'b0;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3) begin
				dout <= s3;
			end
		end
	end
endmodule // sab_sync

// *** rtl/sab_fifo2.v ***
// Two-entry byte buffer with valid and ready on both sides.
`timescale 1ns/1ps
module sab_fifo2 (
	input wire clk_sys, // System clock.
	input wire nrst, // Asynchronous reset, active low.
	input wire in_valid, // Writer offers a byte.
	output wire in_ready, // Buffer has room.
	input wire [7:0] in_data, // Byte offered.
	output wire out_valid, // Buffer holds a byte.
	input wire out_ready, // Reader takes the byte.
	output wire [7:0] out_data // Oldest byte.
);
	reg [7:0] mem [0:1];
	reg wr_ptr;
	reg rd_ptr;
	reg [1:0] count;
	wire push;
	wire pop;

	assign in_ready = (count != 2'h2);
	assign out_valid = (count != 2'h0);
	assign out_data = mem[rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			mem[0] <= 8'h00;
			mem[1] <= 8'h00;
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count <= 2'h0;
		end else begin
			if (push) begin
				mem[wr_ptr] <= in_data;
				wr_ptr <= ~wr_ptr;
			end
			if (pop) begin
				rd_ptr <= ~rd_ptr;
			end
			if (push && !pop) begin
				count <= count + 2'h1;
			end else if (pop && !push) begin
				count <= count - 2'h1;
			end
		end
	end
endmodule // sab_fifo2

// *** rtl/sab_loader.v ***
// Auto-boot loader: masters a serial EEPROM and executes its command stream.
`timescale 1ns/1ps
`include "sab_map.vh"

// Summary of operation
// - High strap at reset selects boot mode, fetching commands from serial EEPROM.
// - In boot mode chip select and serial clock become driven outputs.
// - Load starts with chip select low, clock toggling, command shifted out.
// - First eight bits sent are the fixed read opcode 00000011.
// - Returned bytes are interpreted and override defaults of addressed registers.
// - Every fetched command is issued exactly as a host command would be.
// - A write is one command byte plus three data bytes, MSB first.
// - Page 1 command 60 writes the operation-mode register.
// - Page 1 command 42 writes the current-channel gain register.
// - Page 0 command 74 writes the interrupt mask register.
// - Page 0 command 78 with the STOP bit set ends fetching from the EEPROM.
module sab_loader (
	input wire clk_sys, // System clock, 100 MHz.
	input wire nrst, // Asynchronous reset, active low.
	input wire mode_strap_pin, // Boot mode strap, high selects boot.
	input wire serial_data_in_pin, // Serial data from the EEPROM.
	output reg chip_sel_n_o, // Chip select level, active low.
	output reg chip_sel_oe_n, // Chip select enable, low drives.
	output reg ser_clk_o, // Serial clock level.
	output reg ser_clk_oe_n, // Serial clock enable, low drives.
	output reg serial_data_out_pin, // Serial data toward the EEPROM.
	output reg boot_busy, // Boot load in progress.
	output reg boot_done, // Boot load ended by STOP.
	output reg host_slave_mode, // Serial port handed back to the host.
	output reg exec_valid, // Decoded command offered to the core.
	input wire exec_ready, // Core accepts the command.
	output reg [7:0] exec_cmd, // Command byte.
	output reg [23:0] exec_data, // Data word, zero for one-byte commands.
	output reg [4:0] exec_page, // Register page in force for the command.
	output reg [4:0] page, // Current register page.
	output reg [23:0] opmode_reg, // Operation-mode register.
	output reg [23:0] cur_gain_reg, // Current-channel gain register.
	output reg [23:0] int_mask_reg, // Interrupt mask register.
	output reg [23:0] control_reg // Control register.
);
	localparam [7:0] HALF = `SAB_SCLK_HALF_CYC;
	// Opcode and start address leave as one 16-bit header, MSB first.
	localparam [15:0] HEADER = {`SAB_READ_OPCODE, `SAB_START_ADDR};
	localparam [2:0] ST_SETTLE = 3'h0;
	localparam [2:0] ST_SEND = 3'h1;
	localparam [2:0] ST_READ = 3'h2;
	localparam [2:0] ST_DONE = 3'h3;
	localparam [2:0] ST_SLAVE = 3'h4;

	function is_write;
		input [7:0] c;
		begin
			is_write = (c[7:6] == `SAB_WR_CLASS);
		end
	endfunction

	// Apart from the page command, a register write lands only when page and command both match.
	function reg_hit;
		input [12:0] key;
		input [12:0] want;
		begin
			reg_hit = (key == want);
		end
	endfunction

	wire mode_s;
	wire din_s;
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [7:0] fifo_out_data;
	wire fifo_out_ready;
	wire pop;
	wire tick;
	wire run;
	wire [12:0] exec_key;

	reg [2:0] state;
	reg [2:0] settle_cnt;
	reg [7:0] div_cnt;
	reg [3:0] bit_cnt;
	reg [15:0] tx_sh;
	reg [7:0] rx_sh;
	reg byte_pend;
	reg stop_hit;
	reg [1:0] byte_idx;
	reg [7:0] cmd_hold;
	reg [15:0] data_sh;

	// Both pins cross from outside the clock domain. The strap is read once
	// per reset, so a bounce after the decision has no effect.
	sab_sync u_mode (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.din(mode_strap_pin),
		.dout(mode_s)
	);

	sab_sync u_din (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.din(serial_data_in_pin),
		.dout(din_s)
	);

	// A full buffer stops the serial clock between bytes, so the EEPROM
	// simply waits and no byte is lost while the core stalls.
	sab_fifo2 u_buf (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.in_valid(byte_pend),
		.in_ready(fifo_in_ready),
		.in_data(rx_sh),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	assign tick = (div_cnt == HALF - 8'h01);
	// The divider pauses while a received byte is pending, at least one cycle per byte, which always
	// falls in a low phase, so the clock is stretched between bytes.
	assign run = (state == ST_SEND) || ((state == ST_READ) && !byte_pend);
	assign fifo_out_ready = (state == ST_READ) && !exec_valid && !stop_hit;
	assign pop = fifo_out_valid && fifo_out_ready;
	assign exec_key = {exec_page, exec_cmd};

	// Serial master: strap decision, opcode and address, byte reception.
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state <= ST_SETTLE;
			settle_cnt <= 3'h0;
			div_cnt <= 8'h00;
			bit_cnt <= 4'h0;
			tx_sh <= 16'h0000;
			rx_sh <= 8'h00;
			byte_pend <= 1'b0;
			chip_sel_n_o <= 1'b1;
			chip_sel_oe_n <= 1'b1;
			ser_clk_o <= 1'b0;
			ser_clk_oe_n <= 1'b1;
			serial_data_out_pin <= 1'b0;
			boot_busy <= 1'b0;
			boot_done <= 1'b0;
			host_slave_mode <= 1'b0;
		end else begin
			if (byte_pend && fifo_in_ready) begin
				byte_pend <= 1'b0;
			end
			if (run) begin
				div_cnt <= tick ? 8'h00 : div_cnt + 8'h01;
			end
			case (state)
				ST_SETTLE: begin
					// The strap is judged only after the synchroniser has settled.
					settle_cnt <= settle_cnt + 3'h1;
					if (settle_cnt == `SAB_STRAP_SETTLE) begin
						if (mode_s) begin
							state <= ST_SEND;
							chip_sel_oe_n <= 1'b0;
							ser_clk_oe_n <= 1'b0;
							chip_sel_n_o <= 1'b0;
							serial_data_out_pin <= HEADER[15];
							tx_sh <= {HEADER[14:0], 1'b0};
							boot_busy <= 1'b1;
						end else begin
							state <= ST_SLAVE;
							host_slave_mode <= 1'b1;
						end
					end
				end
				ST_SEND: begin
					if (tick) begin
						if (!ser_clk_o) begin
							ser_clk_o <= 1'b1;
						end else begin
							ser_clk_o <= 1'b0;
							serial_data_out_pin <= tx_sh[15];
							tx_sh <= {tx_sh[14:0], 1'b0};
							bit_cnt <= bit_cnt + 4'h1;
							if (bit_cnt == `SAB_TX_BITS) begin
								state <= ST_READ;
								bit_cnt <= 4'h0;
								// Data out rests low while bytes come back.
								serial_data_out_pin <= 1'b0;
							end
						end
					end
				end
				ST_READ: begin
					if (stop_hit) begin
						// Chip select rises at once; the enables follow a cycle
						// later, so the pin is never left floating while low.
						state <= ST_DONE;
						chip_sel_n_o <= 1'b1;
						ser_clk_o <= 1'b0;
					end else if (tick) begin
						if (!ser_clk_o) begin
							ser_clk_o <= 1'b1;
						end else begin
							// Sampled just before the falling edge, where the
							// EEPROM has held the bit for a full high phase.
							ser_clk_o <= 1'b0;
							rx_sh <= {rx_sh[6:0], din_s};
							bit_cnt <= bit_cnt + 4'h1;
							if (bit_cnt[2:0] == `SAB_RX_BITS) begin
								byte_pend <= 1'b1;
								bit_cnt <= 4'h0;
							end
						end
					end
				end
				ST_DONE: begin
					// Bytes still buffered or pending after STOP are dropped.
					byte_pend <= 1'b0;
					chip_sel_oe_n <= 1'b1;
					ser_clk_oe_n <= 1'b1;
					boot_busy <= 1'b0;
					boot_done <= 1'b1;
					host_slave_mode <= 1'b1;
					state <= ST_SLAVE;
				end
				ST_SLAVE: begin
					// The strap is not judged again until the next reset; the
					// host owns the port from here.
					state <= ST_SLAVE;
				end
				default: begin
					state <= ST_SETTLE;
				end
			endcase
		end
	end

	// Command parser and register update. One command is held at a time;
	// while the core stalls it, the buffer fills and the link stops, which
	// is the back-pressure the serial side relies on.
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			byte_idx <= 2'h0;
			cmd_hold <= 8'h00;
			data_sh <= 16'h0000;
			stop_hit <= 1'b0;
			exec_valid <= 1'b0;
			exec_cmd <= 8'h00;
			exec_data <= 24'h000000;
			exec_page <= `SAB_PAGE_RST;
			page <= `SAB_PAGE_RST;
			opmode_reg <= `SAB_OPMODE_RST;
			cur_gain_reg <= `SAB_IGAIN_RST;
			int_mask_reg <= `SAB_MASK_RST;
			control_reg <= `SAB_CTRL_RST;
		end else begin
			if (pop) begin
				if (byte_idx == 2'h0) begin
					cmd_hold <= fifo_out_data;
					if (is_write(fifo_out_data)) begin
						byte_idx <= 2'h1;
					end else begin
						exec_valid <= 1'b1;
						exec_cmd <= fifo_out_data;
						exec_data <= 24'h000000;
						exec_page <= page;
					end
				end else begin
					data_sh <= {data_sh[7:0], fifo_out_data};
					if (byte_idx == 2'h3) begin
						byte_idx <= 2'h0;
						exec_valid <= 1'b1;
						exec_cmd <= cmd_hold;
						exec_data <= {data_sh, fifo_out_data};
						exec_page <= page;
					end else begin
						byte_idx <= byte_idx + 2'h1;
					end
				end
			end
			if (exec_valid && exec_ready) begin
				exec_valid <= 1'b0;
				if (exec_cmd == `SAB_CMD_PAGE) begin
					page <= exec_data[4:0];
				end
				if (reg_hit(exec_key, {`SAB_PAGE1, `SAB_CMD_OPMODE})) begin
					opmode_reg <= exec_data;
				end
				if (reg_hit(exec_key, {`SAB_PAGE1, `SAB_CMD_IGAIN})) begin
					cur_gain_reg <= exec_data;
				end
				if (reg_hit(exec_key, {`SAB_PAGE0, `SAB_CMD_MASK})) begin
					int_mask_reg <= exec_data;
				end
				// STOP counts only on page 0, where the control register
				// lives; the same code on another page is a plain write.
				if (reg_hit(exec_key, {`SAB_PAGE0, `SAB_CMD_CTRL})) begin
					control_reg <= exec_data;
					if (exec_data[`SAB_STOP_POS]) begin
						stop_hit <= 1'b1;
					end
				end
			end
		end
	end
endmodule // sab_loader

// *** tb/sab_eeprom_model.sv ***
// Behavioural serial memory that serves the boot stream in mode 0.
`timescale 1ns/1ps
module sab_eeprom_model (
	input wire cs_n, // Chip select, active low.
	input wire sck, // Serial clock from the loader.
	input wire mosi, // Data from the loader.
	output reg miso, // Data toward the loader.
	output reg [15:0] hdr // Opcode and address received.
);
	reg [7:0] mem [0:31];
	integer r;
	initial begin
		miso = 1'b0;
		hdr = 16'h0000;
		r = 0;
	end
	always @(negedge cs_n) begin
		r = 0;
	end
	// A released line must not keep showing the last bit.
	always @(posedge cs_n) begin
		miso = ~miso;
	end
	always @(posedge sck) begin
		if (!cs_n && r < 16)
			hdr = {hdr[14:0], mosi};
		if (!cs_n)
			r = r + 1;
	end
	always @(negedge sck) begin
		if (!cs_n && r >= 16)
			miso = mem[(r - 16) / 8][7 - (r - 16) % 8];
	end
endmodule // sab_eeprom_model

// *** tb/sab_loader_checker.sv ***
// Port assertions for the auto-boot loader.
`timescale 1ns/1ps
module sab_loader_checker (
	input wire clk_sys, // Clock.
	input wire nrst, // Reset.
	input wire chip_sel_n_o, // CS level.
	input wire chip_sel_oe_n, // CS enable.
	input wire ser_clk_o, // Clock level.
	input wire ser_clk_oe_n, // Clock enable.
	input wire serial_data_out_pin, // Data out.
	input wire boot_busy, // Busy.
	input wire boot_done, // Done.
	input wire host_slave_mode, // Handed back.
	input wire exec_valid, // Offered.
	input wire exec_ready, // Taken.
	input wire [7:0] exec_cmd, // Command.
	input wire [23:0] exec_data, // Data.
	input wire [4:0] exec_page, // Page.
	input wire [23:0] opmode_reg, // Mode.
	input wire [23:0] cur_gain_reg, // Gain.
	input wire [23:0] int_mask_reg // Mask.
);
	reg [7:0] hi_cnt;
	wire acc = exec_valid && exec_ready;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			hi_cnt <= 8'h00;
		else
			hi_cnt <= ser_clk_o ? hi_cnt + 8'h01 : 8'h00;
	end
	AST_OE_PAIR: assert property (chip_sel_oe_n == ser_clk_oe_n)
		else $error("enables differ");
	AST_CS_OWNED: assert property (!chip_sel_n_o |->
		!chip_sel_oe_n && boot_busy)
		else $error("cs low outside boot");
	AST_DOUT_FALL: assert property ($changed(serial_data_out_pin) |->
		$fell(ser_clk_o))
		else $error("data moved off falling clock");
	AST_SCLK_HIGH: assert property ($fell(ser_clk_o) && !chip_sel_n_o |->
		hi_cnt == 8'h32)
		else $error("clock high phase length");
	AST_TAKE_DROP: assert property (acc |=> !exec_valid)
		else $error("valid after accept");
	AST_HOLD: assert property (exec_valid && !exec_ready |=>
		exec_valid && $stable(exec_cmd) && $stable(exec_data))
		else $error("offer changed");
	AST_OPMODE: assert property (acc && exec_cmd == 8'h60 &&
		exec_page == 5'h01 |=> opmode_reg == $past(exec_data))
		else $error("mode write");
	AST_GAIN: assert property (acc && exec_cmd == 8'h42 &&
		exec_page == 5'h01 |=> cur_gain_reg == $past(exec_data))
		else $error("gain write");
	AST_MASK: assert property (acc && exec_cmd == 8'h74 &&
		exec_page == 5'h00 |=> int_mask_reg == $past(exec_data))
		else $error("mask write");
	AST_STOP: assert property (acc && exec_cmd == 8'h78 &&
		exec_page == 5'h00 && exec_data[8] |-> ##3 boot_done &&
		host_slave_mode && chip_sel_oe_n && !boot_busy)
		else $error("stop did not end boot");
endmodule // sab_loader_checker
bind sab_loader sab_loader_checker chk (.*);

// *** tb/sab_loader_test.sv ***
// Self-checking bench for the auto-boot loader.
`timescale 1ns/1ps
module sab_loader_test;
	reg clk_sys = 1'b0;
	reg nrst = 1'b0;
	reg strap = 1'b0;
	reg exec_ready = 1'b0;
	wire din_w, cs_n, cs_oe, sck, sck_oe, dout_w, busy, done, hsm, ev;
	wire [7:0] cmd;
	wire [23:0] dat, opm, gain, mask, ctl;
	wire [4:0] epg, pg;
	wire [15:0] hdr;
	// Chip select idles high and the clock low when nobody drives them.
	wire cs_w = cs_oe ? 1'b1 : cs_n;
	wire sck_w = sck_oe ? 1'b0 : sck;
	reg [36:0] exp [0:6];
	reg [36:0] got [$];
	integer err_count = 0;
	integer n_tests = 0;
	integer nrise = 0;
	integer i, k, n;
	always #5 clk_sys = ~clk_sys;
	sab_loader dut (.clk_sys(clk_sys), .nrst(nrst), .mode_strap_pin(strap),
		.serial_data_in_pin(din_w), .chip_sel_n_o(cs_n), .chip_sel_oe_n(cs_oe),
		.ser_clk_o(sck), .ser_clk_oe_n(sck_oe), .serial_data_out_pin(dout_w),
		.boot_busy(busy), .boot_done(done), .host_slave_mode(hsm),
		.exec_valid(ev), .exec_ready(exec_ready), .exec_cmd(cmd),
		.exec_data(dat), .exec_page(epg), .page(pg), .opmode_reg(opm),
		.cur_gain_reg(gain), .int_mask_reg(mask), .control_reg(ctl));
	sab_eeprom_model eep (.cs_n(cs_w), .sck(sck_w), .mosi(dout_w),
		.miso(din_w), .hdr(hdr));
	always @(posedge clk_sys) begin
		if (ev && exec_ready)
			got.push_back({epg, cmd, dat});
	end
	always @(posedge sck_w) nrise = nrise + 1;
	task chk(input [63:0] g, input [63:0] e);
		n_tests = n_tests + 1;
		if (g !== e) begin
			err_count = err_count + 1;
			$display("[ERR] t=%0t got %h expected %h", $time, g, e);
		end
	endtask
	task conclude;
		$display("tests %0d errors %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task cyc(input integer c);
		repeat (c) @(posedge clk_sys);
		#1;
	endtask
	task rst(input s);
		cyc(1);
		nrst = 1'b0;
		strap = s;
		cyc(12);
		nrst = 1'b1;
	endtask
	// The core stalls long enough to fill the buffer and stop the link.
	task t_boot;
		rst(1'b1);
		cyc(8000);
		n = nrise;
		cyc(1000);
		chk(nrise, n);
		chk(busy, 1'b1);
		exec_ready = 1'b1;
		for (k = 0; k < 40000 && done !== 1'b1; k = k + 1)
			cyc(1);
		if (done !== 1'b1) begin
			err_count = err_count + 1;
			$display("[ERR] t=%0t boot never ended", $time);
			conclude;
		end
		cyc(3);
		chk(got.size(), 7);
		for (i = 0; i < 7; i = i + 1)
			chk(got[i], exp[i]);
		chk(hdr, 16'h0300);
		chk({opm, gain}, 48'h0001E07FC4A9);
		chk({mask, ctl, pg}, {24'h000004, 24'h000100, 5'h00});
		chk({cs_oe, sck_oe, hsm, busy, cs_w}, 5'h1D);
		n = nrise;
		cyc(500);
		chk(nrise, n);
		$display("test boot finished");
	endtask
	task t_strap_low;
		exec_ready = 1'b0;
		rst(1'b0);
		n = nrise;
		cyc(300);
		chk({cs_oe, sck_oe, hsm, busy, done, cs_w}, 6'h39);
		chk(|{opm, gain, mask, ctl, pg}, 1'b0);
		chk(nrise, n);
		$display("test strap low finished");
	endtask
	initial begin
		exp[0] = {5'h00, 8'h7E, 24'h000001};
		exp[1] = {5'h01, 8'h60, 24'h0001E0};
		exp[2] = {5'h01, 8'h42, 24'h7FC4A9};
		exp[3] = {5'h01, 8'h7E, 24'h000000};
		exp[4] = {5'h00, 8'h74, 24'h000004};
		exp[5] = {5'h00, 8'hE8, 24'h000000};
		exp[6] = {5'h00, 8'h78, 24'h000100};
		for (i = 0; i < 32; i = i + 1)
			eep.mem[i] = 8'hFF;
		n = 0;
		for (i = 0; i < 7; i = i + 1) begin
			eep.mem[n] = exp[i][31:24];
			n = n + 1;
			for (k = 0; k < 3 && exp[i][31:30] == 2'h1; k = k + 1) begin
				eep.mem[n] = exp[i][23 - 8 * k -: 8];
				n = n + 1;
			end
		end
		t_boot;
		t_strap_low;
		conclude;
	end
endmodule // sab_loader_test
